// ===== hdl/samc_core.sv
// Notes on behaviour
// [R1] Chip select low enables logic for conversion
// [R2] Rising link clock samples serial input
// [R3] First high sample is the start bit; the code ignores it while the result FIFO is full
// [R4] Controller sends three or four assignment bits
// [R5] Last address bit applies mux, starts conversion
// [R6] Serial input ignored throughout the conversion
// [R7] One settling period driving a low bit
// [R8] Result bits leave MSB first, one per clock
// [R9] After eight result clocks flag drops low
// [R10] Four-channel variant repeats result LSB first
// [R11] Eight-channel holds LSB while select high
// [R12] Select low shifts nine-bit register LSB first
// [R13] Chip select high clears all, outputs float; the code keeps the result FIFO entries
// [R14] New conversion needs select edge and start
// [R15] Input sampled only while output floats
// [R16] Positive below negative gives all zeros
// [R17] Differential pairs only adjacent channels
// [R18] Four-channel address decode
// [R19] Eight-channel address decode
// [R20] Pseudodifferential uses shared negative input
// [R21] Address order: mode, odd, select bits
// [R22] Serial output changes on falling edge
`timescale 1ns/100ps
`include "samc_defines.svh"

module samc_core (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic lsb_first_enable_n,
  input wire logic eight_channel,
  input wire logic comp_above,
  input wire logic inputs_reversed,
  output logic serial_out,
  output logic serial_out_oe,
  output logic converting_flag,
  output logic converting_flag_oe,
  output samc_pkg::samc_mux_sel_type mux_sel,
  output logic [`SAMC_RES_BITS-1:0] trial_code,
  output logic [`SAMC_RES_BITS-1:0] result_data,
  output logic result_valid,
  input wire logic result_ready
);

  // Mux decode for both variants
  function automatic samc_pkg::samc_mux_sel_type decode_mux(
    input logic [`SAMC_ADDR_REG_BITS-1:0] bits,
    input logic eight
  );
    logic single;
    logic odd;
    logic [1:0] sel;
    samc_pkg::samc_mux_sel_type m;
    single = eight ? bits[3] : bits[2];
    odd = eight ? bits[2] : bits[1];
    sel = eight ? bits[1:0] : {1'b0, bits[0]};
    m.valid = 1'b1;
    m.pos_ch = {sel, odd}; // see [R18] see [R19]
    m.neg_ch = {sel, ~odd}; // see [R17]
    m.neg_shared = single && eight; // see [R20]
    m.neg_ground = single && !eight; // see [R18]
    return m;
  endfunction

  // Every pin is asynchronous to sys_clk
  samc_pkg::samc_pins_type pins_raw;
  samc_pkg::samc_pins_type sync1_q;
  samc_pkg::samc_pins_type sync2_q;
  logic link_clk_prev_q;

  assign pins_raw.link_clk = link_clk;
  assign pins_raw.cs_n = chip_select_n;
  assign pins_raw.din = serial_in;
  assign pins_raw.lsb_en_n = lsb_first_enable_n;
  assign pins_raw.comp_above = comp_above;
  assign pins_raw.reversed = inputs_reversed;
  assign pins_raw.eight_ch = eight_channel;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Reset to the idle pin levels so no frame or select glitch follows release
      sync1_q <= '{cs_n: 1'b1, lsb_en_n: 1'b1, default: 1'b0};
      sync2_q <= '{cs_n: 1'b1, lsb_en_n: 1'b1, default: 1'b0};
      link_clk_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      link_clk_prev_q <= sync2_q.link_clk;
    end
  end

  wire selected;
  wire clk_rise;
  wire clk_fall;
  wire din_s;
  wire comp_eff;
  wire lsb_shift_ok;
  wire fifo_in_ready;
  logic variant_q;

  // Pins float high when undriven; reset keeps the device deselected
  assign selected = !sync2_q.cs_n; // see [R1]
  assign clk_rise = sync2_q.link_clk && !link_clk_prev_q;
  assign clk_fall = !sync2_q.link_clk && link_clk_prev_q;
  assign din_s = sync2_q.din;
  // A reversed input pair can only decide zeros
  assign comp_eff = sync2_q.comp_above && !sync2_q.reversed; // see [R16]
  assign lsb_shift_ok = !variant_q || !sync2_q.lsb_en_n; // see [R10] see [R12]

  samc_pkg::samc_state_type state_q;
  samc_pkg::samc_state_type state_d;
  logic [`SAMC_ADDR_REG_BITS-1:0] addr_q;
  logic [`SAMC_ADDR_REG_BITS-1:0] addr_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [`SAMC_RES_BITS-1:0] approx_q;
  logic [`SAMC_RES_BITS-1:0] approx_d;
  logic [`SAMC_RES_BITS-1:0] mask_q;
  logic [`SAMC_RES_BITS-1:0] mask_d;
  logic [`SAMC_RES_BITS-1:0] trial_q;
  logic [`SAMC_RES_BITS-1:0] trial_d;
  logic [`SAMC_LSB_REG_BITS-1:0] lsb_q;
  logic [`SAMC_LSB_REG_BITS-1:0] lsb_d;
  samc_pkg::samc_mux_sel_type mux_q;
  samc_pkg::samc_mux_sel_type mux_d;
  logic out_q;
  logic out_d;
  logic oe_q;
  logic oe_d;
  logic busy_q;
  logic busy_d;
  logic push;
  wire [3:0] addr_need;
  wire [3:0] cnt_inc;
  wire [`SAMC_ADDR_REG_BITS-1:0] addr_shift;

  assign addr_need = variant_q ? `SAMC_ADDR_BITS_8CH : `SAMC_ADDR_BITS_4CH; // see [R4]
  assign cnt_inc = cnt_q + 4'h1;
  // Bits enter in the order mode, odd/even, select high, select low; four channels send no select high
  assign addr_shift = {addr_q[`SAMC_ADDR_REG_BITS-2:0], din_s}; // see [R21]

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    approx_d = approx_q;
    mask_d = mask_q;
    trial_d = trial_q;
    lsb_d = lsb_q;
    mux_d = mux_q;
    out_d = out_q;
    oe_d = oe_q;
    busy_d = busy_q;
    push = 1'b0;
    if (!selected) begin
      // Deselect wipes the conversion registers, not the result FIFO, and floats both drivers
      state_d = samc_pkg::SAMC_ST_IDLE; // see [R13] see [R14]
      addr_d = '0;
      cnt_d = `SAMC_RST_CNT;
      approx_d = `SAMC_RST_BYTE;
      mask_d = `SAMC_RST_BYTE;
      trial_d = `SAMC_RST_BYTE;
      lsb_d = '0;
      mux_d = '0;
      out_d = 1'b0;
      oe_d = 1'b0;
      busy_d = 1'b0;
    end else begin
      unique case (state_q)
        samc_pkg::SAMC_ST_IDLE: begin
          // Low samples are dropped; start is held off while results back up
          if (clk_rise && din_s && fifo_in_ready) begin // see [R2] see [R3]
            state_d = samc_pkg::SAMC_ST_ADDR;
            addr_d = '0;
            cnt_d = `SAMC_RST_CNT;
          end
        end
        samc_pkg::SAMC_ST_ADDR: begin
          if (clk_rise) begin // see [R2] see [R15]
            addr_d = addr_shift;
            cnt_d = cnt_inc;
            if (cnt_inc == addr_need) begin
              state_d = samc_pkg::SAMC_ST_SETTLE; // see [R5]
              mux_d = decode_mux(addr_shift, variant_q);
              busy_d = 1'b1;
            end
          end
        end
        samc_pkg::SAMC_ST_SETTLE: begin
          if (clk_fall) begin
            oe_d = 1'b1; // see [R7] see [R22]
            out_d = 1'b0;
            approx_d = `SAMC_RST_BYTE;
            mask_d = `SAMC_MSB_MASK;
            trial_d = `SAMC_MSB_MASK;
            cnt_d = `SAMC_RST_CNT;
            state_d = samc_pkg::SAMC_ST_CONV;
          end
        end
        samc_pkg::SAMC_ST_CONV: begin
          // serial_in is not looked at here
          if (clk_rise && comp_eff) begin // see [R6]
            approx_d = approx_q | mask_q;
          end
          if (clk_fall) begin
            out_d = |(approx_q & mask_q); // see [R8] see [R22]
            mask_d = mask_q >> 1;
            trial_d = approx_q | (mask_q >> 1);
            cnt_d = cnt_inc;
            if (cnt_q == `SAMC_CONV_LAST) begin
              busy_d = 1'b0; // see [R9]
              lsb_d = {1'b0, approx_q};
              push = 1'b1;
              state_d = samc_pkg::SAMC_ST_TAIL;
            end
          end
        end
        samc_pkg::SAMC_ST_TAIL: begin
          // LSB stays on the line until shifting is allowed
          if (clk_fall && lsb_shift_ok) begin // see [R10] see [R11] see [R12]
            lsb_d = lsb_q >> 1;
            out_d = lsb_q[1]; // see [R22]
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= samc_pkg::SAMC_ST_IDLE;
      addr_q <= '0;
      cnt_q <= `SAMC_RST_CNT;
      approx_q <= `SAMC_RST_BYTE;
      mask_q <= `SAMC_RST_BYTE;
      trial_q <= `SAMC_RST_BYTE;
      lsb_q <= '0;
      mux_q <= '0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      approx_q <= approx_d;
      mask_q <= mask_d;
      trial_q <= trial_d;
      lsb_q <= lsb_d;
      mux_q <= mux_d;
      out_q <= out_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
    end
  end

  // Variant strap is taken only while deselected, so it cannot move mid-frame
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      variant_q <= 1'b0;
    end else if (!selected) begin
      variant_q <= sync2_q.eight_ch;
    end
  end

  logic flag_oe_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_oe_q <= 1'b0;
    end else begin
      flag_oe_q <= selected; // see [R13]
    end
  end

  samc_fifo #(
    .WIDTH(`SAMC_RES_BITS),
    .DEPTH(`SAMC_FIFO_DEPTH)
  ) u_result_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_data(approx_q),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(result_data),
    .out_valid(result_valid),
    .out_ready(result_ready)
  );

  assign serial_out = out_q;
  assign serial_out_oe = oe_q; // see [R15]
  assign converting_flag = busy_q;
  assign converting_flag_oe = flag_oe_q;
  assign mux_sel = mux_q;
  assign trial_code = trial_q;

endmodule // samc_core

// ===== hdl/samc_fifo.sv
`timescale 1ns/100ps

module samc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire do_push;
  wire do_pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (do_push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (do_pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end

endmodule // samc_fifo

// ===== inc/samc_defines.svh
`ifndef SAMC_DEFINES_SVH
`define SAMC_DEFINES_SVH

// Result and address widths
`define SAMC_RES_BITS 8
`define SAMC_CH_BITS 3
`define SAMC_ADDR_BITS_4CH 4'h3
`define SAMC_ADDR_BITS_8CH 4'h4
`define SAMC_ADDR_REG_BITS 4
`define SAMC_LSB_REG_BITS 9

// Successive approximation timing, in link clock periods, and first trial mask
`define SAMC_CONV_LAST 4'h7
`define SAMC_MSB_MASK 8'h80

// Input synchroniser width
`define SAMC_SYNC_BITS 7

// Result FIFO shape
`define SAMC_FIFO_DEPTH 4

// Reset values
`define SAMC_RST_BYTE 8'h00
`define SAMC_RST_CNT 4'h0

`endif

// ===== inc/samc_pkg.sv
package samc_pkg;

  typedef enum logic [2:0] {
    SAMC_ST_IDLE,
    SAMC_ST_ADDR,
    SAMC_ST_SETTLE,
    SAMC_ST_CONV,
    SAMC_ST_TAIL
  } samc_state_type;

  typedef struct packed {
    logic valid;
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
    logic neg_shared;
    logic neg_ground;
  } samc_mux_sel_type;

  typedef struct packed {
    logic link_clk;
    logic cs_n;
    logic din;
    logic lsb_en_n;
    logic comp_above;
    logic reversed;
    logic eight_ch;
  } samc_pins_type;

endpackage

// ===== verif/samc_core_sva.sv
`timescale 1ns/100ps

module samc_core_sva (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic eight_channel,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic converting_flag,
  input wire logic converting_flag_oe,
  input wire samc_pkg::samc_mux_sel_type mux_sel,
  input wire logic result_valid
);
  logic link_q;
  logic [3:0] falls_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Falls seen while converting: the settling one plus eight result bits
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_q <= 1'b0;
      falls_q <= 4'h0;
    end else begin
      link_q <= link_clk;
      if (!converting_flag) falls_q <= 4'h0;
      else if (link_q && !link_clk) falls_q <= falls_q + 4'h1;
    end
  end

  deselect_clear_a:
    assert property (chip_select_n [*5] |-> !serial_out_oe && !converting_flag
      && mux_sel == '0) else $error("outputs live while deselected");
  flag_enable_a:
    assert property (!chip_select_n [*5] |-> converting_flag_oe) else $error("flag not enabled");
  settle_low_a:
    assert property ($rose(serial_out_oe) |-> !serial_out) else $error("settle bit not low");
  fall_edge_a:
    assert property (!chip_select_n && $changed({serial_out, serial_out_oe}) |-> !link_clk)
      else $error("output moved with link clock high");
  start_mux_a:
    assert property ($rose(converting_flag) |-> mux_sel.valid && !serial_out_oe)
      else $error("start without mux");
  conv_length_a:
    assert property ($fell(converting_flag) && !chip_select_n |-> falls_q == 4'h9)
      else $error("conversion length");
  result_push_a:
    assert property ($fell(converting_flag) && !chip_select_n |-> ##[1:3] result_valid)
      else $error("result not queued");
  adjacent_pair_a:
    assert property (mux_sel.valid && !mux_sel.neg_shared && !mux_sel.neg_ground |->
      mux_sel.neg_ch == {mux_sel.pos_ch[2:1], ~mux_sel.pos_ch[0]}) else $error("bad pair");
  neg_kind_a:
    assert property (mux_sel.valid && (mux_sel.neg_shared || mux_sel.neg_ground) |->
      mux_sel.neg_shared == eight_channel && mux_sel.neg_shared != mux_sel.neg_ground
      && (eight_channel || !mux_sel.pos_ch[2])) else $error("bad single-ended select");

  cover property ($fell(converting_flag) && eight_channel);
  cover property ($fell(converting_flag) && !eight_channel);
  cover property ($rose(chip_select_n) && converting_flag);
endmodule // samc_core_sva

// ===== verif/samc_ctrl_model.sv
`timescale 1ns/100ps

module samc_ctrl_model (
  input wire logic sys_clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic link_clk,
  output logic chip_select_n,
  output logic serial_in,
  output logic lsb_first_enable_n
);
  logic last_q = 1'b0;
  // A released line shows the inverse of its last value, never a stale copy
  wire logic line = serial_out_oe ? serial_out : ~last_q;

  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    lsb_first_enable_n = 1'b1;
  end
  always @(posedge link_clk) last_q <= line;

  // Link clock only runs inside a frame
  task automatic run(input logic [3:0] a, input int n, input int pre, input int len,
                     input int lsb_at, output logic [31:0] got);
    got = '0;
    @(negedge sys_clk) chip_select_n = 1'b0;
    for (int k = 0; k < pre + n + 1 + len; k++) begin
      if (k < pre) serial_in = 1'b0;
      else if (k == pre) serial_in = 1'b1;
      else if (k <= pre + n) serial_in = a[pre + n - k];
      else serial_in = ~serial_in;
      repeat (6) @(negedge sys_clk);
      if (k > pre + n) got = {got[30:0], line};
      link_clk = 1'b1;
      // Select drops with the rise, six system clocks ahead of the fall that acts on it
      if (k - pre - n - 1 == lsb_at) lsb_first_enable_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      link_clk = 1'b0;
    end
    chip_select_n = 1'b1;
    lsb_first_enable_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule // samc_ctrl_model

// ===== verif/testbench.sv
`timescale 1ns/100ps

module testbench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic eight_channel = 1'b0;
  logic inputs_reversed = 1'b0;
  logic result_ready = 1'b0;
  logic [7:0] target = 8'h00;
  logic link_clk, chip_select_n, serial_in, lsb_first_enable_n, comp_above;
  logic serial_out, serial_out_oe, converting_flag, converting_flag_oe, result_valid;
  logic [7:0] trial_code, result_data;
  samc_pkg::samc_mux_sel_type mux_sel, ms;
  logic [7:0] q[$];
  int error_cnt = 0;
  int samples_checked = 0;

  // Half-step offset keeps the comparator free of ties
  assign comp_above = {target, 1'b1} > {trial_code, 1'b0};
  initial forever #10 sys_clk = ~sys_clk;
  // Cleared while a frame addresses, so a refused start leaves it empty
  always @(negedge sys_clk) begin
    if (converting_flag === 1'b1) ms <= mux_sel;
    else if (chip_select_n === 1'b0 && serial_out_oe === 1'b0) ms <= '0;
  end

  samc_core samc_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in),
    .lsb_first_enable_n(lsb_first_enable_n), .eight_channel(eight_channel),
    .comp_above(comp_above), .inputs_reversed(inputs_reversed), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .converting_flag(converting_flag),
    .converting_flag_oe(converting_flag_oe), .mux_sel(mux_sel), .trial_code(trial_code),
    .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready));
  samc_ctrl_model samc_ctrl_model_i (.sys_clk(sys_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .link_clk(link_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .lsb_first_enable_n(lsb_first_enable_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conv(input logic e8, input logic [3:0] a, input logic [7:0] t,
                      input logic rv, input int pre, input logic ok);
    logic [31:0] got;
    logic [7:0] r;
    logic [7:0] b;
    logic [2:0] pos;
    logic single;
    logic [31:0] want;
    logic [5:0] sel_seen;
    eight_channel = e8;
    target = t;
    inputs_reversed = rv;
    r = rv ? 8'h00 : t;
    b = {<<{r}};
    pos = e8 ? {a[1:0], a[2]} : {1'b0, a[0], a[1]};
    single = e8 ? a[3] : a[2];
    repeat (2) @(negedge sys_clk);
    samc_ctrl_model_i.run(a, e8 ? 4 : 3, pre, e8 ? 20 : 17, e8 ? 10 : 99, got);
    if (ok) begin
      want = e8 ? {1'b0, r, r[0], r[0], b[6:0], 2'b00} : {1'b0, r, b[6:0], 1'b0};
      chk(got, want);
      sel_seen = {ms.valid, ms.pos_ch, ms.neg_shared, ms.neg_ground};
      chk(sel_seen, {1'b1, pos, single & e8, single & ~e8});
      if (!single) chk(ms.neg_ch, {pos[2:1], ~pos[0]});
      q.push_back(r);
    end else chk(ms.valid, 1'b0);
  endtask

  task automatic pop_all();
    while (q.size() > 0) begin
      chk(result_valid, 1'b1);
      chk(result_data, q.pop_front());
      result_ready = 1'b1;
      @(negedge sys_clk) result_ready = 1'b0;
      @(negedge sys_clk);
    end
    chk(result_valid, 1'b0);
  endtask

  task automatic t_four();
    for (int i = 0; i < 8; i++) begin
      conv(1'b0, i[3:0], 8'hA5 ^ i[7:0], 1'b0, 0, 1'b1);
      pop_all();
    end
    $display("four channel codes done");
  endtask

  task automatic t_eight();
    for (int i = 0; i < 16; i++) begin
      conv(1'b1, i[3:0], {i[3:0], ~i[3:0]}, 1'b0, i % 3, 1'b1);
      pop_all();
    end
    $display("eight channel codes done");
  endtask

  task automatic t_rev();
    conv(1'b0, 4'h1, 8'hC3, 1'b1, 0, 1'b1);
    conv(1'b1, 4'h9, 8'hFF, 1'b1, 1, 1'b1);
    pop_all();
    $display("reversed inputs done");
  endtask

  task automatic t_abort();
    logic [31:0] got;
    samc_ctrl_model_i.run(4'h5, 3, 0, 4, 99, got);
    chk({serial_out_oe, converting_flag, result_valid}, 3'b000);
    conv(1'b0, 4'h2, 8'h00, 1'b0, 1, 1'b1);
    pop_all();
    $display("abort done");
  endtask

  task automatic t_fifo();
    for (int i = 0; i < 4; i++) conv(1'b1, 4'hF, 8'hFF >> i, 1'b0, 0, 1'b1);
    conv(1'b1, 4'h0, 8'h77, 1'b0, 0, 1'b0);
    pop_all();
    $display("full buffer done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1000000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_four();
    t_eight();
    t_rev();
    t_abort();
    t_fifo();
    summarize();
  end
endmodule // testbench

bind samc_core samc_core_sva samc_core_sva_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .link_clk(link_clk), .chip_select_n(chip_select_n), .eight_channel(eight_channel),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .converting_flag(converting_flag),
  .converting_flag_oe(converting_flag_oe), .mux_sel(mux_sel), .result_valid(result_valid));
